// ### design/scan_pkg.sv
package scan_pkg;
	// Register indices; byte address is four times the index
	localparam logic [3:0] IDX_CONTROL = 4'h0;
	localparam logic [3:0] IDX_SECTION = 4'h1;
	localparam logic [3:0] IDX_STATUS = 4'h2;
	localparam logic [5:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
	localparam logic [5:0] ADDR_SECTION = {IDX_SECTION, 2'h0};
	localparam logic [5:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
	// Field positions
	localparam int BIT_ENABLE = 0;
	localparam int BIT_NMI_ARM = 1;
	localparam int BIT_SOFTRST = 7;
	localparam int BIT_BUSY = 0;
	localparam int BIT_OK = 1;
	// Reset values
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [1:0] SECTION_RST = 2'h0;
	localparam logic [7:0] STATUS_RST = 8'h02;
	// Section encodings
	localparam logic [1:0] SEC_FLASH = 2'h0;
	localparam logic [1:0] SEC_BOOT_APP = 2'h1;
	localparam logic [1:0] SEC_BOOT = 2'h2;
	// Timing
	localparam logic [1:0] START_DELAY = 2'h3;
	localparam logic [1:0] FETCH_CYCLES = 2'h3;
	// CRC constants and AXI response codes
	localparam logic [31:0] POLY16 = 32'h00001021;
	localparam logic [31:0] POLY32 = 32'h04c11db7;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef struct packed {
		logic [5:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} wr_req_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_WAIT = 4'b0010,
		ST_FETCH = 4'b0100,
		ST_DONE = 4'b1000
	} scan_state_t;
endpackage : scan_pkg

// ### design/crc_engine.sv
`timescale 1ns/1ps
`default_nettype none
module crc_engine
	import scan_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic use_crc32,
	input wire logic init,
	input wire logic byte_valid,
	input wire logic [7:0] byte_in,
	// Result
	output logic [31:0] crc
);
	logic [31:0] crc_r;
	logic [31:0] crc_nxt;
	logic [31:0] poly;

	assign poly = use_crc32 ? POLY32 : POLY16;

	// MSB first, one byte per step
	always_comb begin
		logic [31:0] c;
		logic fb;
		c = crc_r;
		fb = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			fb = (use_crc32 ? c[31] : c[15]) ^ byte_in[i];
			c = {c[30:0], 1'b0};
			if (fb) begin
				c = c ^ poly;
			end
		end
		crc_nxt = use_crc32 ? c : {16'h0000, c[15:0]};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			crc_r <= CRC_INIT;
		end else if (init) begin
			crc_r <= CRC_INIT;
		end else if (byte_valid) begin
			crc_r <= crc_nxt;
		end
	end

	assign crc = crc_r;
endmodule : crc_engine
`default_nettype wire

// ### design/axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
module axil_slave
	import scan_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Write channels
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read channels
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Register side
	output logic wr_en,
	output wr_req_t wr_req,
	input wire logic [31:0] rd_data,
	input wire logic rd_hit,
	output logic [5:0] rd_addr
);
	logic aw_have_r;
	logic w_have_r;
	logic [5:0] aw_r;
	logic [31:0] w_r;
	logic [3:0] s_r;
	logic wr_fire;

	assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
	assign s_axi_wready = !w_have_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
	assign wr_en = wr_fire;
	assign wr_req = '{addr: aw_r, data: w_r, strb: s_r};
	assign rd_addr = s_axi_araddr;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_r <= 6'h00;
			w_r <= 32'h00000000;
			s_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				aw_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				w_r <= s_axi_wdata;
				s_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_r == ADDR_CONTROL || aw_r == ADDR_SECTION
					|| aw_r == ADDR_STATUS) ? AXI_OKAY : AXI_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_hit ? AXI_OKAY : AXI_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : axil_slave
`default_nettype wire

// ### design/flash_checksum_scanner.sv
// Functional notes
// - Reset strobe clears registers two cycles later
// - Strobe always taken when failure interrupt off
// - Strobe ignored while busy if interrupt armed
// - Failed compare raises NMI when armed
// - Interrupt enable cleared only by system reset
// - Interrupt enable set only while idle
// - Enable write of one starts fresh scan when idle
// - Enable write of zero has no effect
// - Enable reads one after start-up scan
// - Control locked after NMI raised
// - Section select locked while busy or NMI
// - Section codes: flash, boot+app, boot
// - Section reads back start-up checked section
// - Passed bit one after reset, then result
// - Busy bit high for whole scan
// - Scan begins three cycles after enable
// - Failure clears passed; NMI sticks until reset
// - Priority flash access, three cycles per fetch
// - CRC16 or CRC32 chosen by fuse
`timescale 1ns/1ps
`default_nettype none
module flash_checksum_scanner
	import scan_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// AXI4-Lite register bus
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Fuse configuration, static
	input wire logic fuse_crc32,
	input wire logic fuse_startup_scan,
	input wire logic [1:0] fuse_startup_section,
	input wire logic [23:0] boot_end,
	input wire logic [23:0] app_end,
	input wire logic [23:0] flash_end,
	// Flash read port
	output logic flash_req,
	output logic [23:0] flash_addr,
	input wire logic [15:0] flash_rdata,
	output logic cpu_stall,
	// Start-up and interrupt
	output logic startup_done,
	output logic nmi_req
);
	wr_req_t wr_req;
	logic wr_en;
	logic [31:0] rd_data;
	logic rd_hit;
	logic [5:0] rd_addr;

	logic enable_r;
	logic nmi_arm_r;
	logic [1:0] section_r;
	logic ok_r;
	logic nmi_r;
	logic softrst_r;
	logic boot_pend_r;
	logic startup_done_r;
	scan_state_t state_r;
	scan_state_t state_nxt;
	logic [1:0] cnt_r;
	logic [23:0] addr_r;
	logic [23:0] end_r;
	logic crc_init;
	logic crc_step;
	logic [31:0] crc;
	logic [7:0] crc_byte;
	logic hi_half_r;
	logic [15:0] word_r;

	logic busy;
	logic wr_ctrl;
	logic wr_sec;
	logic ctrl_ok;
	logic sec_ok;
	logic start_sw;
	logic start_any;
	logic softrst_acc;
	logic nmi_arm_set;
	logic last_byte;
	logic scan_fail;
	logic [23:0] sel_end;
	logic [7:0] ctrl_val;
	logic [7:0] stat_val;

	axil_slave u_bus (
		.clk(clk),
		.rst(rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_req(wr_req),
		.rd_data(rd_data),
		.rd_hit(rd_hit),
		.rd_addr(rd_addr)
	);

	crc_engine u_crc (
		.clk(clk),
		.rst(rst),
		.use_crc32(fuse_crc32),
		.init(crc_init),
		.byte_valid(crc_step),
		.byte_in(crc_byte),
		.crc(crc)
	);

	// Register write decode
	assign busy = (state_r != ST_IDLE);
	assign wr_ctrl = wr_en && wr_req.addr == ADDR_CONTROL && wr_req.strb[0];
	assign wr_sec = wr_en && wr_req.addr == ADDR_SECTION && wr_req.strb[0];
	assign ctrl_ok = wr_ctrl && !nmi_r && startup_done_r;
	assign sec_ok = wr_sec && !busy && !nmi_r && startup_done_r;
	assign softrst_acc = ctrl_ok && wr_req.data[BIT_SOFTRST]
		&& (!nmi_arm_r || !busy);
	assign nmi_arm_set = ctrl_ok && wr_req.data[BIT_NMI_ARM]
		&& !busy;
	assign start_sw = ctrl_ok && wr_req.data[BIT_ENABLE] && !softrst_acc
		&& !softrst_r;
	assign start_any = start_sw || boot_pend_r;

	// Section end select
	assign sel_end = (section_r == SEC_BOOT) ? boot_end
		: (section_r == SEC_BOOT_APP) ? app_end : flash_end;
	assign last_byte = (addr_r == end_r) && hi_half_r;
	assign scan_fail = fuse_crc32 ? (crc != 32'h00000000)
		: (crc[15:0] != 16'h0000);

	// Scan sequencer
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start_any) begin
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (cnt_r == START_DELAY - 2'h1) begin
					state_nxt = ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (cnt_r == FETCH_CYCLES - 2'h1 && last_byte) begin
					state_nxt = ST_DONE;
				end
			end
			ST_DONE: state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
		if (softrst_r) begin
			state_nxt = ST_IDLE;
		end
	end

	// Two bytes per 16-bit fetch, MSB byte first
	assign crc_byte = hi_half_r ? word_r[7:0] : word_r[15:8];
	assign crc_init = (state_r == ST_WAIT);
	assign crc_step = (state_r == ST_FETCH) && cnt_r != 2'h0;
	assign flash_req = (state_r == ST_FETCH);
	assign flash_addr = addr_r;
	assign cpu_stall = (state_r == ST_FETCH) || !startup_done_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			cnt_r <= 2'h0;
			addr_r <= 24'h000000;
			end_r <= 24'h000000;
			hi_half_r <= 1'b0;
			word_r <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			if (state_r != state_nxt || cnt_r == FETCH_CYCLES - 2'h1) begin
				cnt_r <= 2'h0;
			end else begin
				cnt_r <= cnt_r + 2'h1;
			end
			if (state_r == ST_IDLE) begin
				addr_r <= 24'h000000;
				end_r <= sel_end;
				hi_half_r <= 1'b0;
			end
			if (state_r == ST_FETCH && cnt_r == 2'h0) begin
				word_r <= flash_rdata;
			end
			if (crc_step) begin
				hi_half_r <= !hi_half_r;
				if (!last_byte) begin
					addr_r <= addr_r + 24'h000001;
				end
			end
		end
	end

	// Control and status registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enable_r <= 1'b0;
			nmi_arm_r <= 1'b0;
			section_r <= SECTION_RST;
			ok_r <= STATUS_RST[BIT_OK];
			nmi_r <= 1'b0;
			softrst_r <= 1'b0;
			boot_pend_r <= 1'b0;
			startup_done_r <= 1'b0;
		end else begin
			softrst_r <= softrst_acc;
			boot_pend_r <= 1'b0;
			if (!startup_done_r && !boot_pend_r && state_r == ST_IDLE) begin
				if (fuse_startup_scan && !enable_r) begin
					enable_r <= 1'b1;
					section_r <= fuse_startup_section;
					boot_pend_r <= 1'b1;
				end else if (!fuse_startup_scan || ok_r) begin
					startup_done_r <= 1'b1;
				end
			end
			if (start_sw) begin
				enable_r <= 1'b1;
			end
			if (nmi_arm_set) begin
				nmi_arm_r <= 1'b1;
			end
			if (sec_ok) begin
				section_r <= wr_req.data[1:0];
			end
			if (state_r == ST_DONE) begin
				ok_r <= !scan_fail;
				if (scan_fail && nmi_arm_r) begin
					nmi_r <= 1'b1;
				end
			end
			if (softrst_r) begin
				enable_r <= 1'b0;
				section_r <= SECTION_RST;
				ok_r <= STATUS_RST[BIT_OK];
			end
		end
	end

	assign nmi_req = nmi_r;
	assign startup_done = startup_done_r;

	// Read mux
	assign ctrl_val = {7'h00, enable_r}
		| ({7'h00, nmi_arm_r} << BIT_NMI_ARM);
	assign stat_val = ({7'h00, ok_r} << BIT_OK) | {7'h00, busy};
	assign rd_hit = rd_addr == ADDR_CONTROL || rd_addr == ADDR_SECTION
		|| rd_addr == ADDR_STATUS;
	assign rd_data = (rd_addr == ADDR_CONTROL) ? {24'h000000, ctrl_val}
		: (rd_addr == ADDR_SECTION) ? {30'h00000000, section_r}
		: (rd_addr == ADDR_STATUS) ? {24'h000000, stat_val}
		: 32'h00000000;

	// Checks
	AST_SOFTRST_CLEARS: assert property (
		@(posedge clk) disable iff (rst)
		softrst_acc |=> ##1 (!enable_r && !busy && ok_r))
		else $error("soft reset did not clear");
	AST_STROBE_BUSY: assert property (
		@(posedge clk) disable iff (rst)
		(ctrl_ok && wr_req.data[BIT_SOFTRST] && nmi_arm_r && busy)
		|=> ##1 enable_r)
		else $error("strobe taken while armed busy");
	AST_STROBE_FREE: assert property (
		@(posedge clk) disable iff (rst)
		(ctrl_ok && wr_req.data[BIT_SOFTRST] && !nmi_arm_r)
		|=> ##1 !enable_r)
		else $error("strobe refused while unarmed");
	AST_NMI_RAISE: assert property (
		@(posedge clk) disable iff (rst)
		(state_r == ST_DONE && scan_fail && nmi_arm_r) |=> nmi_req)
		else $error("nmi not raised");
	AST_NMI_STICKY: assert property (
		@(posedge clk) disable iff (rst)
		nmi_req |=> nmi_req)
		else $error("nmi dropped");
	AST_ARM_HOLD: assert property (
		@(posedge clk) disable iff (rst)
		nmi_arm_r |=> nmi_arm_r)
		else $error("interrupt enable cleared");
	AST_ARM_BUSY: assert property (
		@(posedge clk) disable iff (rst)
		(!nmi_arm_r && busy) |=> !nmi_arm_r)
		else $error("interrupt enable set while busy");
	AST_ENABLE_STAYS: assert property (
		@(posedge clk) disable iff (rst)
		(enable_r && !softrst_r) |=> enable_r)
		else $error("enable cleared");
	AST_SEC_LOCK: assert property (
		@(posedge clk) disable iff (rst)
		(busy && !softrst_r && $stable(state_r)) |=> $stable(section_r))
		else $error("section changed while busy");
	AST_CTRL_LOCK: assert property (
		@(posedge clk) disable iff (rst)
		nmi_req |=> ($stable(enable_r) && $stable(section_r)))
		else $error("control changed after nmi");
	sequence seq_start;
		state_r == ST_IDLE && start_any && !softrst_r;
	endsequence
	AST_START_DELAY: assert property (
		@(posedge clk) disable iff (rst)
		seq_start |=> (state_r == ST_WAIT) [*3] ##1 state_r == ST_FETCH)
		else $error("scan start delay wrong");
	sequence seq_fetch_bytes;
		crc_step ##1 crc_step;
	endsequence
	AST_FETCH_RATE: assert property (
		@(posedge clk) disable iff (rst)
		(flash_req && cnt_r == 2'h0 && !softrst_r && !softrst_acc)
		|-> (cpu_stall && !crc_step) ##1 seq_fetch_bytes)
		else $error("fetch pacing wrong");
	AST_OK_RESULT: assert property (
		@(posedge clk) disable iff (rst)
		(state_r == ST_DONE && !softrst_r) |=> ok_r == !$past(scan_fail))
		else $error("passed bit wrong");
endmodule : flash_checksum_scanner
`default_nettype wire

// ### dv/flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
	parameter logic [23:0] BOOT_END = 24'h00000f,
	parameter logic [23:0] APP_END = 24'h00001f,
	parameter logic [23:0] FLASH_END = 24'h00003f
) (
	// Clock
	input wire logic clk,
	// Read port
	input wire logic flash_req,
	input wire logic [23:0] flash_addr,
	output logic [15:0] flash_rdata,
	// Fault injection
	input wire logic corrupt
);
	logic [7:0] mem [64];
	logic [15:0] word;
	logic [15:0] last_r = 16'h0000;

	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {b, 8'h00};
		for (int k = 0; k < 8; k++) begin
			r = r[15] ? ({r[14:0], 1'b0} ^ 16'h1021) : {r[14:0], 1'b0};
		end
		return r;
	endfunction : crc_byte

	// Checksum stored high byte first in the last two bytes
	task automatic seal(input logic [23:0] last);
		logic [15:0] c;
		c = 16'hffff;
		for (int i = 0; i < int'(last) - 1; i++) begin
			c = crc_byte(c, mem[i]);
		end
		mem[last - 1] = c[15:8];
		mem[last] = c[7:0];
	endtask : seal

	initial begin
		for (int i = 0; i < 64; i++) begin
			mem[i] = 8'(i * 7 + 3);
		end
		seal(BOOT_END);
		seal(APP_END);
		seal(FLASH_END);
	end

	assign word = {mem[{flash_addr[5:1], 1'b0}], mem[{flash_addr[5:1], 1'b1}]}
		^ {15'h0000, corrupt};
	// Released bus shows the inverse, not a held value
	assign flash_rdata = flash_req ? word : ~last_r;

	always_ff @(posedge clk) begin
		if (flash_req) last_r <= word;
	end
endmodule : flash_model
`default_nettype wire

// ### dv/flash_checksum_scanner_test.sv
`timescale 1ns/1ps
`default_nettype none
module flash_checksum_scanner_test
	import scan_pkg::*;
;
	localparam logic [23:0] BOOT_END = 24'h00000f;
	localparam logic [23:0] APP_END = 24'h00001f;
	localparam logic [23:0] FLASH_END = 24'h00003f;
	localparam logic [23:0] ENDS [3] = '{FLASH_END, APP_END, BOOT_END};
	typedef struct packed {
		logic [5:0] a;
		logic wr;
		logic [7:0] d;
		logic [31:0] e;
		logic [1:0] r;
	} row_t;
	row_t rows [9] = '{
		'{ADDR_CONTROL, 1'b0, 8'h00, 32'h0, AXI_OKAY},
		'{ADDR_SECTION, 1'b0, 8'h00, 32'h0, AXI_OKAY},
		'{ADDR_STATUS, 1'b0, 8'h00, 32'h2, AXI_OKAY},
		'{ADDR_SECTION, 1'b1, 8'h01, 32'h0, AXI_OKAY},
		'{ADDR_SECTION, 1'b0, 8'h00, 32'h1, AXI_OKAY},
		'{ADDR_SECTION, 1'b1, 8'h02, 32'h0, AXI_OKAY},
		'{ADDR_SECTION, 1'b0, 8'h00, 32'h2, AXI_OKAY},
		'{6'h0c, 1'b0, 8'h00, 32'h0, AXI_SLVERR},
		'{6'h0c, 1'b1, 8'h01, 32'h0, AXI_SLVERR}};
	logic clk;
	logic rst = 1'b1;
	logic [5:0] s_axi_awaddr = 6'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [5:0] s_axi_araddr = 6'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic fuse_crc32 = 1'b0;
	logic fuse_startup_scan = 1'b0;
	logic [1:0] fuse_startup_section = SEC_FLASH;
	logic flash_req;
	logic [23:0] flash_addr;
	logic [15:0] flash_rdata;
	logic cpu_stall;
	logic startup_done;
	logic nmi_req;
	logic corrupt = 1'b0;
	logic [31:0] rd;
	logic [1:0] resp;
	logic [23:0] top_addr;
	int req_cycles = 0;
	int fail_count = 0;
	int check_count = 0;

	flash_checksum_scanner dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fuse_crc32,
		.fuse_startup_scan, .fuse_startup_section, .boot_end(BOOT_END),
		.app_end(APP_END), .flash_end(FLASH_END), .flash_req, .flash_addr,
		.flash_rdata, .cpu_stall, .startup_done, .nmi_req);
	flash_model #(.BOOT_END(BOOT_END), .APP_END(APP_END),
		.FLASH_END(FLASH_END)) model (.clk, .flash_req, .flash_addr,
		.flash_rdata, .corrupt);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask : chk

	task automatic axw(input logic [5:0] a, input logic [7:0] d);
		logic ah;
		logic wh;
		logic bv;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge clk);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bv = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge clk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
		end while (!bv);
		s_axi_bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [5:0] a);
		logic ah;
		logic rv;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge clk);
			ah = s_axi_arvalid && s_axi_arready;
			rv = s_axi_rvalid;
			rd = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge clk);
			if (ah) s_axi_arvalid <= 1'b0;
		end while (!rv);
		s_axi_rready <= 1'b0;
	endtask : axr

	task automatic rdchk(input logic [5:0] a, input logic [31:0] e,
		input string n);
		axr(a);
		chk(n, e, rd);
	endtask : rdchk

	task automatic wait_idle;
		do axr(ADDR_STATUS);
		while (rd[BIT_BUSY] !== 1'b0);
	endtask : wait_idle

	always @(negedge clk) begin
		if (flash_req) begin
			req_cycles++;
			top_addr = flash_addr;
			chk("cpu_stall", 32'h1, {31'h0, cpu_stall});
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		end_of_test;
	end

	task automatic reset_dut;
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		do @(negedge clk);
		while (startup_done !== 1'b1);
	endtask : reset_dut

	initial begin
		reset_dut;
		foreach (rows[i]) begin
			if (rows[i].wr) axw(rows[i].a, rows[i].d);
			else rdchk(rows[i].a, rows[i].e, "row data");
			chk("row resp", {30'h0, rows[i].r}, {30'h0, resp});
		end
		for (int s = 0; s < 3; s++) begin
			axw(ADDR_SECTION, 8'(s));
			req_cycles = 0;
			axw(ADDR_CONTROL, 8'h01);
			axr(ADDR_STATUS);
			chk("busy", 32'h1, {31'h0, rd[BIT_BUSY]});
			if (s == 0) begin
				axw(ADDR_CONTROL, 8'h02);
				axw(ADDR_CONTROL, 8'h00);
				axw(ADDR_SECTION, 8'h01);
			end
			wait_idle;
			chk("pass", 32'h2, rd);
			chk("fetch", 32'(3 * (ENDS[s] + 1) / 2), 32'(req_cycles));
			chk("end", {9'h0, ENDS[s][23:1]}, {9'h0, top_addr[23:1]});
			rdchk(ADDR_CONTROL, 32'h1, "enable");
			rdchk(ADDR_SECTION, 32'(s), "section");
		end
		axw(ADDR_SECTION, 8'h01);
		axw(ADDR_CONTROL, 8'h01);
		axw(ADDR_CONTROL, 8'h80);
		rdchk(ADDR_CONTROL, 32'h0, "ctl strobe");
		rdchk(ADDR_SECTION, 32'h0, "sec strobe");
		rdchk(ADDR_STATUS, 32'h2, "busy strobe");
		axw(ADDR_CONTROL, 8'h02);
		rdchk(ADDR_CONTROL, 32'h2, "arm idle");
		axw(ADDR_CONTROL, 8'h03);
		axw(ADDR_CONTROL, 8'h80);
		axr(ADDR_STATUS);
		chk("strobe ignored", 32'h1, {31'h0, rd[BIT_BUSY]});
		wait_idle;
		axw(ADDR_CONTROL, 8'h80);
		rdchk(ADDR_CONTROL, 32'h2, "arm kept");
		corrupt <= 1'b1;
		axw(ADDR_SECTION, 8'h02);
		axw(ADDR_CONTROL, 8'h01);
		wait_idle;
		chk("fail", 32'h0, rd);
		@(negedge clk);
		chk("nmi", 32'h1, {31'h0, nmi_req});
		axw(ADDR_CONTROL, 8'h80);
		axw(ADDR_SECTION, 8'h00);
		rdchk(ADDR_CONTROL, 32'h3, "ctl locked");
		rdchk(ADDR_SECTION, 32'h2, "sec locked");
		@(negedge clk);
		chk("nmi sticky", 32'h1, {31'h0, nmi_req});
		@(posedge clk);
		corrupt <= 1'b0;
		fuse_startup_scan <= 1'b1;
		fuse_startup_section <= SEC_BOOT_APP;
		reset_dut;
		chk("nmi reset", 32'h0, {31'h0, nmi_req});
		rdchk(ADDR_CONTROL, 32'h1, "boot enable");
		rdchk(ADDR_SECTION, 32'h1, "boot section");
		rdchk(ADDR_STATUS, 32'h2, "boot status");
		fuse_crc32 <= 1'b1;
		fuse_startup_scan <= 1'b0;
		reset_dut;
		axw(ADDR_SECTION, {6'h00, SEC_BOOT});
		axw(ADDR_CONTROL, 8'h01);
		wait_idle;
		chk("crc32 fuse", 32'h0, rd);
		chk("nmi unarmed", 32'h0, {31'h0, nmi_req});
		end_of_test;
	end
endmodule : flash_checksum_scanner_test
`default_nettype wire
